// [core/rcp_pkg.sv]
// package for the radio control port and recovered bit clock block
// assumes one 200 MHz clock and a classic wishbone register bus
package rcp_pkg;
    // ========================================
    // clock and bit rates
    localparam int unsigned CLK_HZ = 200_000_000;
    localparam int unsigned RATE_SLOW_BPS = 4_800;
    localparam int unsigned RATE_FAST_BPS = 19_200;
    localparam int unsigned BIT_CYC_SLOW = CLK_HZ / RATE_SLOW_BPS;
    localparam int unsigned BIT_CYC_FAST = CLK_HZ / RATE_FAST_BPS;
    localparam int PHASE_W = 16;
    // ========================================
    // start pattern and serial grouping
    localparam logic [15:0] START_VECTOR = 16'he2e2;
    localparam logic [2:0] GROUP_LAST = 3'h7;
    localparam int READ_FLAG_BIT = 7;
    // ========================================
    // register map, byte addresses
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_CFG = 8'h08;
    localparam int CTRL_RECOV_EN = 0;
    localparam int CTRL_TXB_LO = 8;
    localparam int ST_ENHANCED = 0;
    localparam int ST_FOUND = 1;
    localparam int ST_RATE_SLOW = 2;
    localparam int ST_MODE_LO = 4;
    localparam int ST_AWAKE = 8;
    // ========================================
    // reset values
    localparam logic RST_RECOV_EN = 1'b0;
    localparam logic [7:0] RST_TX_BYTE = 8'h00;
    localparam logic [7:0] RST_CTRL_REG = 8'h00;
    // ========================================
    // bits of the scanned mode-pin vector
    localparam int PIN_TXRX = 0;
    localparam int PIN_OOKASK = 1;
    localparam int PIN_SLEEP = 2;
    localparam int PIN_START_VECTOR_ENABLE = 3;
    localparam int PIN_RATE = 4;
    // ========================================
    // radio operating mode
    typedef enum logic [1:0] {
        RCP_SLEEP, RCP_TX_OOK, RCP_TX_ASK, RCP_RX
    } rcp_mode_e;
endpackage

// [core/rcp_cfg_if.sv]
// carrier between the core and the serial configuration shifter
// assumes all signals are on clk_i and the levels are already synchronised
`timescale 1ns/100ps
interface rcp_cfg_if;
    logic en;
    logic sel;
    logic sclk_rise;
    logic sdat;
    logic [7:0] tx_byte;
    logic rx_stb;
    logic [7:0] rx_byte;
    logic sdo;
    logic sdo_oe;
    modport core (output en, sel, sclk_rise, sdat, tx_byte,
                  input rx_stb, rx_byte, sdo, sdo_oe);
    modport port (input en, sel, sclk_rise, sdat, tx_byte,
                  output rx_stb, rx_byte, sdo, sdo_oe);
endinterface

// [core/rcp_cfg_shift.sv]
// serial configuration shifter, 8-bit groups
// assumes the core gives synchronised levels and a clock rising pulse
`timescale 1ns/100ps
module rcp_cfg_shift
    import rcp_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // core side
    rcp_cfg_if.port cf
);
    typedef struct packed {
        logic [2:0] cnt;
        logic [7:0] sh;
        logic first;
        logic rd;
        logic sdo;
        logic oe;
        logic [7:0] rxb;
        logic stb;
    } rcp_sh_s;
    rcp_sh_s s_q, s_d;

    always_comb begin
        s_d = s_q;
        s_d.stb = 1'b0;
        // RULE12 RULE20 RULE22: select gates transfers
        if (!cf.en || !cf.sel) begin
            s_d.cnt = 3'h0;
            s_d.first = 1'b1;
            s_d.rd = 1'b0;
        end else if (cf.sclk_rise) begin
            s_d.cnt = s_q.cnt + 3'h1;
            if (s_q.rd) begin
                // RULE15: next read bit driven on rise
                s_d.sdo = s_q.sh[7];
                s_d.sh = {s_q.sh[6:0], 1'b0};
                if (s_q.cnt == GROUP_LAST) begin
                    s_d.sh = cf.tx_byte;
                end
            end else begin
                // RULE13: write bit taken on rise
                s_d.sh = {s_q.sh[6:0], cf.sdat};
                // RULE14: group of 8 to control register unless it is a read command
                if (s_q.cnt == GROUP_LAST) begin
                    s_d.first = 1'b0;
                    if (s_q.first && cf.sdat == 1'b0 &&
                        s_q.sh[READ_FLAG_BIT - 1]) begin
                        s_d.rd = 1'b1;
                        s_d.sh = cf.tx_byte;
                    end else begin
                        s_d.rxb = {s_q.sh[6:0], cf.sdat};
                        s_d.stb = 1'b1;
                    end
                end
            end
        end
        // RULE16: pin released unless a read is running
        s_d.oe = cf.en && cf.sel && s_d.rd;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign cf.rx_stb = s_q.stb;
    assign cf.rx_byte = s_q.rxb;
    assign cf.sdo = s_q.sdo;
    assign cf.sdo_oe = s_q.oe;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    deselect_discard_a: assert property (!cf.sel |=> s_q.cnt == 3'h0) // RULE22
        else $error("partial group kept after deselect");
    legacy_no_drive_a: assert property (!cf.en |=> !s_q.oe) // RULE16
        else $error("config data driven outside enhanced mode");
    group_strobe_a: assert property (
        cf.en && cf.sel && cf.sclk_rise && !s_q.rd &&
        !(s_q.first && !cf.sdat && s_q.sh[READ_FLAG_BIT - 1]) &&
        s_q.cnt == GROUP_LAST |=> s_q.stb && s_q.rxb == $past({s_q.sh[6:0],
        cf.sdat})) // RULE14
        else $error("full group not passed to control register");
endmodule

// [core/rcp_top.sv]
// radio control port: mode straps, serial config port, bit clock recovery
// assumes pins are asynchronous to clk_i and a wishbone master on clk_i
//
// Summary of operation
// RULE1: in enhanced mode, start-vector hunt is armed while enable is high.
// RULE2: no recovered clock pulses until pattern e2e2 seen in sliced data.
// RULE3: host lowers then raises the enable pin to rearm hunting.
// RULE4: host keeps both unused feature inputs low.
// RULE5: rate pin high selects 4.8 kbps, low selects 19.2 kbps.
// RULE6: enhanced strap needs a high select pin after power-up to wake.
// RULE7: legacy strap: host holds enhanced select low throughout.
// RULE8: bit clock stays low while recovery is unused.
// RULE9: with recovery on, bit clock low until start symbol found.
// RULE10: each recovered bit appears at bit clock rise, read at fall.
// RULE11: bit clock keeps running until the enable pin is cycled.
// RULE12: serial configuration transfers only while select is high.
// RULE13: write bits are captured on serial clock rising edges.
// RULE14: each group of 8 received bits goes to the control register; a read command group is not stored and a same-cycle pin change wins.
// RULE15: read bits are driven on serial clock rising edges.
// RULE16: legacy mode never drives the serial lines.
// RULE17: host never leaves mode, select or serial lines floating.
// RULE18: legacy: serial clock and data pins decode sleep, ook, ask, receive.
// RULE19: enhanced: mode pin changes rewrite the configuration register.
// RULE20: select is grounded in legacy, a chip select in enhanced.
// RULE21: data output carries slicer until start found, then recovered data.
// RULE22: select low discards partial groups and ignores serial clocks.
//
// Local design decisions: the Wishbone register port and the address map.
`timescale 1ns/100ps
module rcp_top
    import rcp_pkg::*;
#(
    parameter int unsigned BIT_CYC_SLOW_P = BIT_CYC_SLOW,
    parameter int unsigned BIT_CYC_FAST_P = BIT_CYC_FAST
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // mode pins
    input wire logic mode_strap_i,
    input wire logic enhanced_mode_select_i,
    input wire logic start_vector_enable_i,
    input wire logic rx_rate_select_i,
    input wire logic tx_rx_i,
    input wire logic ook_ask_i,
    input wire logic sleep_i,
    // serial configuration port
    input wire logic config_select_i,
    input wire logic config_serial_clock_i,
    input wire logic config_serial_data_i,
    output logic config_serial_data_o,
    output logic config_serial_data_oe_o,
    // receive path
    input wire logic slicer_data_i,
    output logic recovered_bit_clock_o,
    output logic receive_data_out_o,
    output rcp_mode_e radio_mode_o
);
    // ========================================
    // state
    typedef struct packed {
        logic [1:0] strap_s;
        logic [1:0] ems_s;
        logic [1:0] start_vector_enable_s;
        logic [1:0] rate_s;
        logic [1:0] txrx_s;
        logic [1:0] ookask_s;
        logic [1:0] sleep_s;
        logic [1:0] csel_s;
        logic [1:0] sclk_s;
        logic [1:0] sdat_s;
        logic [1:0] slice_s;
        logic sclk_prev;
        logic slice_prev;
        logic [1:0] fill;
        logic strap_done;
        logic strap_enh;
        logic awake;
        logic found;
        logic [15:0] hunt;
        logic [PHASE_W-1:0] phase;
        logic rec_clk;
        logic rx_out;
        logic recov_en;
        logic [7:0] tx_byte;
        logic [7:0] ctrl_reg;
        logic [4:0] pins_last;
        rcp_mode_e mode;
        logic ack;
        logic [31:0] dat;
    } rcp_top_s;
    rcp_top_s s_q, s_d;

    rcp_cfg_if cf();

    // legacy decode: clock line is the low bit, data line the high bit
    function automatic rcp_mode_e legacy_decode(input logic lo,
                                               input logic hi);
        case ({hi, lo})
            2'b00: legacy_decode = RCP_SLEEP;
            2'b01: legacy_decode = RCP_TX_OOK;
            2'b10: legacy_decode = RCP_TX_ASK;
            default: legacy_decode = RCP_RX;
        endcase
    endfunction

    logic enhanced;
    logic in_use;
    logic [PHASE_W-1:0] bit_cyc;
    logic [PHASE_W-1:0] half_cyc;
    logic [4:0] pins_now;
    logic wb_req;

    assign enhanced = s_q.strap_enh && s_q.awake;
    assign in_use = enhanced && s_q.recov_en && s_q.start_vector_enable_s[1];
    // RULE5: rate pin high is the slow rate
    assign bit_cyc = s_q.rate_s[1] ? PHASE_W'(BIT_CYC_SLOW_P) :
                                     PHASE_W'(BIT_CYC_FAST_P);
    assign half_cyc = {1'b0, bit_cyc[PHASE_W-1:1]};
    assign pins_now = {s_q.rate_s[1], s_q.start_vector_enable_s[1], s_q.sleep_s[1],
                       s_q.ookask_s[1], s_q.txrx_s[1]};
    assign wb_req = wb_cyc_i && wb_stb_i && !s_q.ack;

    assign cf.en = enhanced;
    assign cf.sel = s_q.csel_s[1];
    assign cf.sclk_rise = s_q.sclk_s[1] && !s_q.sclk_prev;
    assign cf.sdat = s_q.sdat_s[1];
    assign cf.tx_byte = s_q.tx_byte;

    rcp_cfg_shift u_shift (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .cf (cf)
    );

    always_comb begin
        s_d = s_q;
        // ========================================
        // two-flop synchronisers; stage 0 only feeds stage 1
        s_d.strap_s = {s_q.strap_s[0], mode_strap_i};
        s_d.ems_s = {s_q.ems_s[0], enhanced_mode_select_i};
        s_d.start_vector_enable_s = {s_q.start_vector_enable_s[0], start_vector_enable_i};
        s_d.rate_s = {s_q.rate_s[0], rx_rate_select_i};
        s_d.txrx_s = {s_q.txrx_s[0], tx_rx_i};
        s_d.ookask_s = {s_q.ookask_s[0], ook_ask_i};
        s_d.sleep_s = {s_q.sleep_s[0], sleep_i};
        s_d.csel_s = {s_q.csel_s[0], config_select_i};
        s_d.sclk_s = {s_q.sclk_s[0], config_serial_clock_i};
        s_d.sdat_s = {s_q.sdat_s[0], config_serial_data_i};
        s_d.slice_s = {s_q.slice_s[0], slicer_data_i};
        s_d.sclk_prev = s_q.sclk_s[1];
        s_d.slice_prev = s_q.slice_s[1];
        // ========================================
        // strap caught once the synchroniser has filled after reset
        s_d.fill = {s_q.fill[0], 1'b1};
        if (!s_q.strap_done && s_q.fill[1]) begin
            s_d.strap_done = 1'b1;
            s_d.strap_enh = s_q.strap_s[1];
        end
        // RULE6 RULE7: enhanced strap wakes on select high
        if (s_q.strap_done && s_q.strap_enh && s_q.ems_s[1]) begin
            s_d.awake = 1'b1;
        end
        // ========================================
        // bit timing: phase restarts on every slicer transition
        if (s_q.slice_s[1] != s_q.slice_prev ||
            s_q.phase >= bit_cyc - PHASE_W'(1)) begin
            s_d.phase = '0;
        end else begin
            s_d.phase = s_q.phase + PHASE_W'(1);
        end
        // RULE10: clock falls at bit boundary, bit stable for host
        if (s_d.phase == '0) begin
            s_d.rec_clk = 1'b0;
        end
        // RULE3 RULE11: only leaving use clears the found state, by a low enable or by recov_en cleared
        if (!in_use) begin
            s_d.found = 1'b0;
            s_d.hunt = '0;
            // RULE8: no clock while recovery unused
            s_d.rec_clk = 1'b0;
        end else if (s_q.phase == half_cyc) begin
            if (s_q.found) begin
                // RULE10: new bit and clock rise together
                s_d.rx_out = s_q.slice_s[1];
                s_d.rec_clk = 1'b1;
            end else begin
                // RULE1 RULE2: hunt for the start pattern
                s_d.hunt = {s_q.hunt[14:0], s_q.slice_s[1]};
                s_d.found = {s_q.hunt[14:0], s_q.slice_s[1]} ==
                            START_VECTOR;
            end
        end
        // RULE9 RULE21: slicer passes straight through until found
        if (!s_q.found) begin
            s_d.rec_clk = 1'b0;
            s_d.rx_out = s_q.slice_s[1];
        end
        // ========================================
        // configuration register and operating mode
        if (cf.rx_stb) begin
            s_d.ctrl_reg = cf.rx_byte;
        end
        // RULE19: mode pin change rewrites the configuration
        if (enhanced && pins_now != s_q.pins_last) begin
            s_d.pins_last = pins_now;
            s_d.ctrl_reg = {3'h0, pins_now};
        end
        if (!enhanced) begin
            // RULE18: serial lines as static control bits
            s_d.mode = legacy_decode(s_q.sclk_s[1], s_q.sdat_s[1]);
        end else if (s_q.ctrl_reg[PIN_SLEEP]) begin
            s_d.mode = RCP_SLEEP;
        end else if (!s_q.ctrl_reg[PIN_TXRX]) begin
            s_d.mode = RCP_RX;
        end else begin
            s_d.mode = s_q.ctrl_reg[PIN_OOKASK] ? RCP_TX_OOK : RCP_TX_ASK;
        end
        // ========================================
        // wishbone slave: one wait state, ack drops the next cycle
        s_d.ack = wb_req;
        s_d.dat = '0;
        if (wb_req && wb_we_i && wb_adr_i == ADDR_CTRL) begin
            if (wb_sel_i[0]) begin
                s_d.recov_en = wb_dat_i[CTRL_RECOV_EN];
            end
            if (wb_sel_i[1]) begin
                s_d.tx_byte = wb_dat_i[CTRL_TXB_LO +: 8];
            end
        end
        if (wb_req && !wb_we_i) begin
            case (wb_adr_i)
                ADDR_CTRL: begin
                    s_d.dat[CTRL_RECOV_EN] = s_q.recov_en;
                    s_d.dat[CTRL_TXB_LO +: 8] = s_q.tx_byte;
                end
                ADDR_STATUS: begin
                    s_d.dat[ST_ENHANCED] = enhanced;
                    s_d.dat[ST_FOUND] = s_q.found;
                    s_d.dat[ST_RATE_SLOW] = s_q.rate_s[1];
                    s_d.dat[ST_MODE_LO +: 2] = s_q.mode;
                    s_d.dat[ST_AWAKE] = s_q.awake;
                end
                ADDR_CFG: s_d.dat[7:0] = s_q.ctrl_reg;
                default: s_d.dat = '0;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q <= '0;
            s_q.recov_en <= RST_RECOV_EN;
            s_q.tx_byte <= RST_TX_BYTE;
            s_q.ctrl_reg <= RST_CTRL_REG;
            s_q.mode <= RCP_SLEEP;
        end else begin
            s_q <= s_d;
        end
    end

    // ========================================
    // outputs
    assign wb_dat_o = s_q.dat;
    assign wb_ack_o = s_q.ack;
    assign config_serial_data_o = cf.sdo;
    assign config_serial_data_oe_o = cf.sdo_oe;
    assign recovered_bit_clock_o = s_q.rec_clk;
    assign receive_data_out_o = s_q.rx_out;
    assign radio_mode_o = s_q.mode;

    // ========================================
    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence seq_found_hold;
        s_q.found && in_use;
    endsequence

    clock_unused_low_a: assert property (!in_use |=> !s_q.rec_clk) // RULE8
        else $error("bit clock high while recovery unused");
    no_clock_early_a: assert property (!s_q.found |=> !s_q.rec_clk) // RULE2
        else $error("bit clock before start pattern");
    found_held_a: assert property (seq_found_hold |=> s_q.found) // RULE11
        else $error("found state lost without enable cycle");
    enable_rearm_a: assert property (
        s_q.found ##1 !s_q.start_vector_enable_s[1] |=> !s_q.found) // RULE3
        else $error("low enable did not clear recognition");
    slicer_pass_a: assert property (
        !s_q.found |=> s_q.rx_out == $past(s_q.slice_s[1])) // RULE21
        else $error("slicer data not passed through");
    legacy_decode_a: assert property (!enhanced |=> s_q.mode ==
        legacy_decode($past(s_q.sclk_s[1]), $past(s_q.sdat_s[1]))) // RULE18
        else $error("legacy mode decode wrong");
    bus_ack_a: assert property (wb_req |=> s_q.ack ##1 !s_q.ack)
        else $error("wishbone ack not a single pulse");

    // strap capture and wake
    strap_capture_a: assert property ( // RULE6
        s_q.fill[1] && !s_q.strap_done |=>
        s_q.strap_done && s_q.strap_enh == $past(s_q.strap_s[1]))
        else $error("power-up strap not captured");
    wake_on_select_a: assert property ( // RULE6
        s_q.strap_done && s_q.strap_enh && s_q.ems_s[1] |=> s_q.awake)
        else $error("enhanced strap did not wake");
    legacy_asleep_a: assert property ( // RULE7
        s_q.strap_done && !s_q.strap_enh |=> !s_q.awake)
        else $error("legacy strap woke enhanced mode");

    // start pattern and recovered bits
    sequence seq_start_match;
        in_use && !s_q.found && s_q.phase == half_cyc &&
        {s_q.hunt[14:0], s_q.slice_s[1]} == START_VECTOR;
    endsequence
    start_match_a: assert property (seq_start_match |=> s_q.found) // RULE2
        else $error("start pattern missed");
    bit_on_rise_a: assert property ( // RULE10
        $rose(s_q.rec_clk) |-> s_q.rx_out == $past(s_q.slice_s[1]))
        else $error("recovered bit not set at clock rise");
    bit_held_a: assert property ( // RULE10
        s_q.rec_clk |=> $stable(s_q.rx_out) || !s_q.rec_clk)
        else $error("recovered bit changed while clock high");

    // configuration register
    pin_rewrite_a: assert property ( // RULE19
        enhanced && pins_now != s_q.pins_last |=>
        s_q.ctrl_reg == {3'h0, $past(pins_now)})
        else $error("mode pin change not written");
    group_store_a: assert property ( // RULE14
        cf.rx_stb && pins_now == s_q.pins_last |=>
        s_q.ctrl_reg == $past(cf.rx_byte))
        else $error("serial group not stored");
endmodule

// [dv/rcp_host_model.sv]
// host controller model: mode pins, serial config port, slicer stream
// assumes the bench resolves the shared data line and calls the tasks
`timescale 1ns/100ps
module rcp_host_model #(
    parameter int BIT_CYC = 20
) (
    // clock
    input wire logic clk_i,
    // data line as resolved by the bench
    input wire logic sdat_line_i,
    // host driven pins
    output logic esel_o,
    output logic [4:0] pins_o,
    output logic sel_o,
    output logic sclk_o,
    output logic sdat_o,
    output logic slicer_o
);
    // ========================================
    // pin levels
    // every line defined
    // unused feature pins are tied low off the model
    initial begin
        esel_o = 1'b0;
        pins_o = 5'h00;
        sel_o = 1'b0;
        sclk_o = 1'b0;
        sdat_o = 1'b0;
        slicer_o = 1'b0;
    end
    // enable cycling, wake and legacy hold
    task automatic set_pins(input logic esel, input logic [4:0] p);
        @(posedge clk_i);
        esel_o <= esel;
        pins_o <= p;
        repeat (20) @(posedge clk_i);
    endtask
    // ========================================
    // serial port
    // select framing
    task automatic frame(input logic on);
        @(posedge clk_i);
        sel_o <= on;
        repeat (8) @(posedge clk_i);
    endtask
    // set while low, read taken at the fall
    task automatic xfer(input logic [7:0] tx, input int n,
                        output logic [7:0] rx);
        for (int i = 0; i < n; i++) begin
            sdat_o <= tx[7 - i];
            repeat (8) @(posedge clk_i);
            sclk_o <= 1'b1;
            repeat (8) @(posedge clk_i);
            rx[7 - i] = sdat_line_i;
            sclk_o <= 1'b0;
        end
    endtask
    task automatic ctrl(input logic c, input logic d);
        @(posedge clk_i);
        sclk_o <= c;
        sdat_o <= d;
        repeat (10) @(posedge clk_i);
    endtask
    // ========================================
    // sliced receive stream, msb first
    task automatic stream(input logic [15:0] b);
        @(posedge clk_i);
        for (int i = 15; i >= 0; i--) begin
            slicer_o <= b[i];
            repeat (BIT_CYC) @(posedge clk_i);
        end
    endtask
endmodule

// [dv/radio_ctrl_port_and_rx_clock_tb.sv]
// bench: wishbone tasks plus host model driving pins and serial port
// assumes rcp_top with short bit periods and a 200 MHz clock
`timescale 1ns/100ps
module radio_ctrl_port_and_rx_clock_tb;
    import rcp_pkg::*;
    localparam int FAST = 20;
    logic clk_i = 1'b0;
    logic rst_i;
    logic wb_cyc, wb_stb, wb_we, wb_ack, strap;
    logic [7:0] wb_adr;
    logic [3:0] wb_sel;
    logic [31:0] wb_wdat, wb_rdat;
    logic esel, sel, sclk, sdat_h, slicer, sdat_o, sdat_oe, rbc, rxd;
    logic [4:0] pins;
    wire logic sdat_line = sdat_oe ? sdat_o : sdat_h;
    rcp_mode_e mode;
    int n_fail = 0;
    int checks_done = 0;
    logic rx_q[$];
    logic [4:0] pv [4] = '{5'h04, 5'h00, 5'h13, 5'h01};
    rcp_mode_e pm [4] = '{RCP_SLEEP, RCP_RX, RCP_TX_OOK, RCP_TX_ASK};
    rcp_top #(.BIT_CYC_SLOW_P(40), .BIT_CYC_FAST_P(FAST)) uut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
        .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
        .mode_strap_i(strap), .enhanced_mode_select_i(esel),
        .start_vector_enable_i(pins[PIN_START_VECTOR_ENABLE]),
        .rx_rate_select_i(pins[PIN_RATE]), .tx_rx_i(pins[PIN_TXRX]),
        .ook_ask_i(pins[PIN_OOKASK]), .sleep_i(pins[PIN_SLEEP]),
        .config_select_i(sel), .config_serial_clock_i(sclk),
        .config_serial_data_i(sdat_line), .config_serial_data_o(sdat_o),
        .config_serial_data_oe_o(sdat_oe), .slicer_data_i(slicer),
        .recovered_bit_clock_o(rbc), .receive_data_out_o(rxd),
        .radio_mode_o(mode));
    rcp_host_model #(.BIT_CYC(FAST)) host (
        .clk_i(clk_i), .sdat_line_i(sdat_line), .esel_o(esel),
        .pins_o(pins), .sel_o(sel), .sclk_o(sclk), .sdat_o(sdat_h),
        .slicer_o(slicer));
    always #2.5 clk_i = ~clk_i;
    always @(negedge rbc) rx_q.push_back(rxd);
    // ========================================
    // checking and bus tasks
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wb(input logic we, input logic [7:0] a,
                      input logic [31:0] d, input logic [3:0] s,
                      output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= a;
        wb_sel <= s;
        wb_wdat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack !== 1'b1 && n < 20);
        q = wb_rdat;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        if (n >= 20) n_fail++;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s);
        logic [31:0] q;
        wb(1'b1, a, d, s, q);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] e, input string nm);
        logic [31:0] q;
        wb(1'b0, a, 32'h0, 4'hf, q);
        chk(nm, e, q & m);
    endtask
    task automatic close_out();
        if (n_fail == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge clk_i);
        n_fail++;
        close_out();
    end
    // ========================================
    // test sequence
    initial begin
        logic [7:0] b;
        logic [15:0] v;
        int n;
        rst_i <= 1'b1;
        strap <= 1'b1;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
        wb_adr <= 8'h00;
        wb_sel <= 4'h0;
        wb_wdat <= 32'h0;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(ADDR_STATUS, 32'h101, 32'h000, "asleep");
        rd(ADDR_CTRL, 32'hffff, 32'h0, "ctrl_rst");
        host.set_pins(1'b1, 5'h00);
        rd(ADDR_STATUS, 32'h101, 32'h101, "awake");
        wr(ADDR_CTRL, 32'h0000a500, 4'h2);
        wr(ADDR_CTRL, 32'hffffff00, 4'h1);
        wr(8'h0c, 32'hffffffff, 4'hf);
        rd(ADDR_CTRL, 32'hffffffff, 32'ha500, "ctrl");
        rd(8'h0c, 32'hffffffff, 32'h0, "unmapped");
        for (int i = 0; i < 4; i++) begin
            host.set_pins(1'b1, pv[i]);
            rd(ADDR_CFG, 32'hff, {27'h0, pv[i]}, "cfg_pins");
            chk("mode", {30'h0, pm[i]}, {30'h0, mode});
            rd(ADDR_STATUS, 32'h34,
               {26'h0, pm[i], 1'b0, pv[i][4], 2'h0}, "rate");
        end
        host.frame(1'b1);
        host.xfer(8'h35, 8, b);
        host.frame(1'b0);
        rd(ADDR_CFG, 32'hff, 32'h35, "cfg_wr");
        host.frame(1'b1);
        host.xfer(8'hff, 5, b);
        host.frame(1'b0);
        host.frame(1'b1);
        host.xfer(8'h4b, 8, b);
        host.frame(1'b0);
        rd(ADDR_CFG, 32'hff, 32'h4b, "cfg_part");
        host.xfer(8'h2c, 8, b);
        rd(ADDR_CFG, 32'hff, 32'h4b, "cfg_desel");
        host.frame(1'b1);
        host.xfer(8'h80, 8, b);
        chk("oe_rd", 1, sdat_oe);
        host.xfer(8'h00, 8, b);
        chk("rd_byte", 32'ha5, b);
        host.frame(1'b0);
        chk("oe_off", 0, sdat_oe);
        rd(ADDR_CFG, 32'hff, 32'h4b, "cfg_rdcmd");
        wr(ADDR_CTRL, 32'h1, 4'h1);
        host.set_pins(1'b1, 5'h00);
        host.stream(16'he2e2);
        rd(ADDR_STATUS, 32'h2, 32'h0, "unarmed");
        wr(ADDR_CTRL, 32'h0, 4'h1);
        host.set_pins(1'b1, 5'h08);
        rx_q.delete();
        host.stream(16'he2e2);
        chk("no_recov", 0, rx_q.size());
        wr(ADDR_CTRL, 32'h1, 4'h1);
        host.stream(16'h00ff);
        chk("slicer", 1, rxd);
        host.stream(16'he2e2);
        chk("pre_found", 0, rx_q.size());
        rd(ADDR_STATUS, 32'h2, 32'h2, "found");
        host.stream(16'h3c5a);
        repeat (2 * FAST) @(posedge clk_i);
        for (int i = 0; i < 16; i++) v = {v[14:0], rx_q[i]};
        chk("rx_bits", 32'h3c5a, v);
        n = rx_q.size();
        repeat (10 * FAST) @(posedge clk_i);
        chk("running", 1, rx_q.size() >= n + 8);
        host.set_pins(1'b1, 5'h00);
        rd(ADDR_STATUS, 32'h2, 32'h0, "cleared");
        rx_q.delete();
        repeat (5 * FAST) @(posedge clk_i);
        chk("stopped", 0, rx_q.size());
        host.set_pins(1'b1, 5'h08);
        host.stream(16'he2e2);
        rd(ADDR_STATUS, 32'h2, 32'h2, "rearmed");
        strap <= 1'b0;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        host.set_pins(1'b0, 5'h00);
        rd(ADDR_STATUS, 32'h1, 32'h0, "legacy");
        for (int i = 0; i < 4; i++) begin
            host.ctrl(i[0], i[1]);
            chk("leg_mode", i, {30'h0, mode});
            chk("leg_oe", 0, sdat_oe);
        end
        close_out();
    end
endmodule
